// File: include/angle_host_pkg.sv
// Constants, timing counts and types for the angle sensor host controller
package angle_host_pkg;

    // ==================================================================
    // Clock and word layout
    localparam int SYS_CLK_PERIOD_NS = 25;
    localparam int WORD_BITS = 16;
    localparam int RX_BITS = 17;
    localparam int PULSE_CNT_W = 5;
    localparam int ADDR_BITS = 5;
    localparam int DATA_BITS = 8;
    localparam logic [4:0] WORD_LEN = 5'h10;
    localparam logic [4:0] SSI_DUMMY_LEN = 5'h01;
    localparam logic [2:0] CMD_REG_READ = 3'h2;
    localparam logic [2:0] CMD_REG_WRITE = 3'h4;
    localparam logic [7:0] READ_FILL = 8'h00;

    // ==================================================================
    // Operations and controller states
    typedef enum logic [1:0] {
        OP_SPI_ANGLE = 2'h0,
        OP_REG_READ = 2'h1,
        OP_REG_WRITE = 2'h2,
        OP_SSI_ANGLE = 2'h3
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_SHIFT = 3'h2,
        ST_HOLD = 3'h3,
        ST_WAIT2 = 3'h4
    } state_t;

    // ==================================================================
    // Link timing, in printed units, and derived cycle counts
    localparam int ANGLE_GAP_NS = 150;
    localparam int REG_GAP_NS = 750;
    localparam int CS_SETUP_NS = 80;
    localparam int CS_HOLD_NS = 25;
    localparam int SSI_DEAD_US = 40;
    localparam int NVM_WAIT_MS = 20;
    localparam int SPI_MAX_MHZ = 25;

    // Least time rounded up to whole cycles, never below one
    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ANGLE_GAP_CYC = min_cycles(ANGLE_GAP_NS);
    localparam int REG_GAP_CYC = min_cycles(REG_GAP_NS);
    localparam int CS_SETUP_CYC = min_cycles(CS_SETUP_NS);
    localparam int CS_HOLD_CYC = min_cycles(CS_HOLD_NS);
    localparam int SSI_DEAD_CYC = min_cycles(SSI_DEAD_US * 1000);
    localparam int NVM_WAIT_CYC = min_cycles(NVM_WAIT_MS * 1000000);
    localparam int SPI_MIN_HALF_CYC = min_cycles(1000 / SPI_MAX_MHZ / 2);
    // Half period must also cover the two-stage input synchroniser
    localparam int DEF_HALF_CYC = 4;
    localparam int TMR_W = 8;

endpackage

// File: core/serial_shifter.sv
// Clock pulse generator and shift engine shared by the SPI and SSI links
`timescale 1ns/1ps
module serial_shifter #(
    parameter int HALF_CYC = angle_host_pkg::DEF_HALF_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic idle_level_i,
    input wire logic [angle_host_pkg::PULSE_CNT_W-1:0] pulses_i,
    input wire logic [angle_host_pkg::WORD_BITS-1:0] tx_word_i,
    input wire logic rx_bit_i,
    output logic clk_o,
    output logic tx_bit_o,
    output logic busy_o,
    output logic done_o,
    output logic [angle_host_pkg::RX_BITS-1:0] rx_word_o
);
    import angle_host_pkg::*;

    localparam int DIV_W = $clog2(HALF_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);

    logic [DIV_W-1:0] div_r;
    logic [PULSE_CNT_W-1:0] cnt_r;
    logic [WORD_BITS-1:0] tx_r;
    logic [RX_BITS-1:0] rx_r;
    logic busy_r;
    logic clk_r;
    logic done_r;

    // ==================================================================
    // Edge decode
    wire tick = busy_r && (div_r == DIV_LAST);
    wire rise = tick && !clk_r;
    wire fall = tick && clk_r;
    wire back_idle = tick && ((~clk_r) == idle_level_i);
    wire last = back_idle && (cnt_r == (pulses_i - 5'h01));
    wire [DIV_W-1:0] div_nxt = tick ? '0 : div_r + 1'h1;

    // ==================================================================
    // Shift engine: sample on rising edge, next output bit on falling
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= '0;
            cnt_r <= '0;
            tx_r <= '0;
            rx_r <= '0;
            busy_r <= 1'h0;
            clk_r <= 1'h0;
            done_r <= 1'h0;
        end else begin
            done_r <= last;
            if (start_i && !busy_r) begin
                busy_r <= 1'h1;
                div_r <= '0;
                cnt_r <= '0;
                tx_r <= tx_word_i;
                rx_r <= '0;
                clk_r <= idle_level_i;
            end else if (busy_r) begin
                div_r <= div_nxt;
                if (tick) begin
                    clk_r <= ~clk_r;
                end
                if (rise) begin
                    rx_r <= {rx_r[RX_BITS-2:0], rx_bit_i};
                end
                if (fall) begin
                    tx_r <= {tx_r[WORD_BITS-2:0], 1'h0};
                end
                if (back_idle) begin
                    cnt_r <= cnt_r + 1'h1;
                end
                if (last) begin
                    busy_r <= 1'h0;
                end
            end
        end
    end

    assign clk_o = busy_r ? clk_r : idle_level_i;
    assign tx_bit_o = tx_r[WORD_BITS-1];
    assign busy_o = busy_r;
    assign done_o = done_r;
    assign rx_word_o = rx_r;

endmodule

// File: core/angle_sensor_host.sv
// Host controller driving an angle sensor over its SPI and SSI pins
// Summary of operation
// - Sixteen-bit words; optional seventeenth clock returns parity
// - Sample rising, drive falling, select idles high, MSB first
// - Serial clock kept at or below 25 MHz
// - Every command frame is sixteen bits on MOSI
// - Angle read up to sixteen clocks, MOSI zero
// - Read request: 010, address, eight zero bits
// - Write request: 100, address, new value
// - Wait 20 ms between write request and response
// - Select idle 150 ns between angles, 750 ns around registers
// - SSI dummy clock first, data MSB next, parity last
// - SSI clock high 40 us between reads
`timescale 1ns/1ps
module angle_sensor_host #(
    parameter int HALF_CYC = angle_host_pkg::DEF_HALF_CYC,
    parameter int NVM_WAIT_CYCLES = angle_host_pkg::NVM_WAIT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire angle_host_pkg::op_t cmd_op_i,
    input wire logic [angle_host_pkg::ADDR_BITS-1:0] cmd_addr_i,
    input wire logic [angle_host_pkg::DATA_BITS-1:0] cmd_wdata_i,
    input wire logic [angle_host_pkg::PULSE_CNT_W-1:0] cmd_bits_i,
    input wire logic cmd_parity_i,
    output logic rsp_valid_o,
    output logic [angle_host_pkg::WORD_BITS-1:0] rsp_data_o,
    output logic rsp_parity_bit_o,
    output logic rsp_parity_err_o,
    output logic rsp_match_o,
    output logic spi_cs_n_o,
    output logic spi_sclk_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i,
    output logic ssi_clock_o,
    input wire logic ssi_data_i
);
    import angle_host_pkg::*;

    // Idle counter must reach the longer of the write wait and the SSI dead time
    localparam int GAP_MAX = (NVM_WAIT_CYCLES > SSI_DEAD_CYC) ? NVM_WAIT_CYCLES : SSI_DEAD_CYC;
    localparam int GAP_W = $clog2(GAP_MAX + 1);

    // ==================================================================
    // Helpers
    function automatic logic [4:0] eff_bits(input logic [4:0] b);
        return ((b == 5'h00) || (b > WORD_LEN)) ? WORD_LEN : b;
    endfunction

    // Conservative idle time before the next select or SSI frame
    function automatic int gap_need(input op_t op, input op_t last);
        int g;
        g = ANGLE_GAP_CYC;
        if ((op == OP_SSI_ANGLE) || (last == OP_SSI_ANGLE)) begin
            g = SSI_DEAD_CYC;
        end else if ((op != OP_SPI_ANGLE) || (last != OP_SPI_ANGLE)) begin
            g = REG_GAP_CYC;
        end
        return g;
    endfunction

    // Drop parity and dummy bits, left align the data bits
    function automatic logic [15:0] align_word(input logic [16:0] rx, input logic [4:0] d,
                                               input logic p);
        logic [16:0] v;
        v = p ? (rx >> 1) : rx;
        v = v << (WORD_LEN - d);
        return v[15:0];
    endfunction

    // ==================================================================
    // Registers
    state_t state_r;
    state_t state_nxt;
    op_t op_r;
    op_t last_op_r;
    logic [ADDR_BITS-1:0] addr_r;
    logic [DATA_BITS-1:0] wdata_r;
    logic [PULSE_CNT_W-1:0] bits_r;
    logic par_r;
    logic frame2_r;
    logic cs_n_r;
    logic [TMR_W-1:0] tmr_r;
    logic [GAP_W-1:0] idle_cnt_r;
    logic miso_meta_r;
    logic miso_sync_r;
    logic ssd_meta_r;
    logic ssd_sync_r;
    logic rsp_valid_r;
    logic [WORD_BITS-1:0] rsp_data_r;
    logic rsp_par_r;
    logic rsp_err_r;
    logic rsp_match_r;
    logic eng_clk;
    logic eng_tx;
    logic eng_busy;
    logic eng_done;
    logic [RX_BITS-1:0] eng_rx;

    // ==================================================================
    // Decode
    wire link_ssi = (op_r == OP_SSI_ANGLE);
    wire reg_op = (op_r == OP_REG_READ) || (op_r == OP_REG_WRITE);
    wire first_of_two = reg_op && !frame2_r;
    wire tmr_zero = (tmr_r == '0);
    wire gap_ok = idle_cnt_r >= GAP_W'(gap_need(cmd_op_i, last_op_r));
    wire accept = cmd_valid_i && cmd_ready_o;
    wire [GAP_W-1:0] wait2_need = (op_r == OP_REG_WRITE) ? GAP_W'(NVM_WAIT_CYCLES)
                                                          : GAP_W'(REG_GAP_CYC);
    wire wait2_ok = (state_r == ST_WAIT2) && (idle_cnt_r >= wait2_need);
    wire eng_start = (state_r == ST_SETUP) && tmr_zero;
    wire hold_done = (state_r == ST_HOLD) && tmr_zero;
    wire ssi_done = (state_r == ST_SHIFT) && eng_done && link_ssi;
    wire finish = (hold_done && !first_of_two) || ssi_done;
    wire link_end = hold_done || ssi_done;
    wire idle_count = ((state_r == ST_IDLE) || (state_r == ST_WAIT2)) && (idle_cnt_r != '1);
    wire [4:0] par_len = {4'h0, par_r};
    wire [4:0] data_bits = reg_op ? WORD_LEN : bits_r;
    wire [4:0] frame_pulses = link_ssi ? (SSI_DUMMY_LEN + bits_r + par_len)
                            : first_of_two ? WORD_LEN
                            : (data_bits + par_len);
    wire [15:0] read_req = {CMD_REG_READ, addr_r, READ_FILL};
    wire [15:0] write_req = {CMD_REG_WRITE, addr_r, wdata_r};
    wire [15:0] tx_word = !first_of_two ? 16'h0000
                        : (op_r == OP_REG_READ) ? read_req : write_req;
    wire [15:0] rx_aligned = align_word(eng_rx, data_bits, par_r);
    wire rx_err = par_r && ((^rx_aligned) ^ eng_rx[0]);
    wire rx_bit = link_ssi ? ssd_sync_r : miso_sync_r;

    assign cmd_ready_o = (state_r == ST_IDLE) && gap_ok && !eng_busy;

    // ==================================================================
    // Control sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (tmr_zero) begin
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (eng_done) begin
                    state_nxt = link_ssi ? ST_IDLE : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (tmr_zero) begin
                    state_nxt = first_of_two ? ST_WAIT2 : ST_IDLE;
                end
            end
            ST_WAIT2: begin
                if (wait2_ok) begin
                    state_nxt = ST_SETUP;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            op_r <= OP_SPI_ANGLE;
            last_op_r <= OP_SPI_ANGLE;
            addr_r <= '0;
            wdata_r <= '0;
            bits_r <= WORD_LEN;
            par_r <= 1'h0;
            frame2_r <= 1'h0;
        end else begin
            state_r <= state_nxt;
            if (accept) begin
                op_r <= cmd_op_i;
                addr_r <= cmd_addr_i;
                wdata_r <= cmd_wdata_i;
                bits_r <= eff_bits(cmd_bits_i);
                par_r <= cmd_parity_i;
                frame2_r <= 1'h0;
            end
            if (hold_done && first_of_two) begin
                frame2_r <= 1'h1;
            end
            if (finish) begin
                last_op_r <= op_r;
            end
        end
    end

    // Select line, frame timer and idle-time counter
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_n_r <= 1'h1;
            tmr_r <= '0;
            idle_cnt_r <= '1;
        end else begin
            if ((accept && (cmd_op_i != OP_SSI_ANGLE)) || wait2_ok) begin
                cs_n_r <= 1'h0;
            end else if (hold_done) begin
                cs_n_r <= 1'h1;
            end
            if (accept || wait2_ok) begin
                tmr_r <= TMR_W'(CS_SETUP_CYC);
            end else if ((state_r == ST_SHIFT) && eng_done) begin
                tmr_r <= TMR_W'(CS_HOLD_CYC);
            end else if (!tmr_zero) begin
                tmr_r <= tmr_r - 1'h1;
            end
            if (link_end) begin
                idle_cnt_r <= '0;
            end else if (idle_count) begin
                idle_cnt_r <= idle_cnt_r + 1'h1;
            end
        end
    end

    // Pin synchronisers and response capture
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            miso_meta_r <= 1'h0;
            miso_sync_r <= 1'h0;
            ssd_meta_r <= 1'h0;
            ssd_sync_r <= 1'h0;
            rsp_valid_r <= 1'h0;
            rsp_data_r <= '0;
            rsp_par_r <= 1'h0;
            rsp_err_r <= 1'h0;
            rsp_match_r <= 1'h0;
        end else begin
            miso_meta_r <= spi_miso_i;
            miso_sync_r <= miso_meta_r;
            ssd_meta_r <= ssi_data_i;
            ssd_sync_r <= ssd_meta_r;
            rsp_valid_r <= finish;
            if (finish) begin
                rsp_data_r <= rx_aligned;
                rsp_par_r <= par_r & eng_rx[0];
                rsp_err_r <= rx_err;
                rsp_match_r <= (op_r == OP_REG_WRITE) && (rx_aligned[15:8] == wdata_r);
            end
        end
    end

    // ==================================================================
    // Shift engine and pin routing
    serial_shifter #(
        .HALF_CYC(HALF_CYC)
    ) u_shifter (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i(eng_start),
        .idle_level_i(link_ssi),
        .pulses_i(frame_pulses),
        .tx_word_i(tx_word),
        .rx_bit_i(rx_bit),
        .clk_o(eng_clk),
        .tx_bit_o(eng_tx),
        .busy_o(eng_busy),
        .done_o(eng_done),
        .rx_word_o(eng_rx)
    );

    assign spi_cs_n_o = cs_n_r;
    assign spi_sclk_o = link_ssi ? 1'h0 : eng_clk;
    assign spi_mosi_o = link_ssi ? 1'h0 : eng_tx;
    assign ssi_clock_o = link_ssi ? eng_clk : 1'h1;
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_data_o = rsp_data_r;
    assign rsp_parity_bit_o = rsp_par_r;
    assign rsp_parity_err_o = rsp_err_r;
    assign rsp_match_o = rsp_match_r;

    // ==================================================================
    // Checks
    logic sclk_q_r;
    logic ssi_clock_q_r;
    logic [4:0] sclk_rises_r;
    logic [4:0] ssi_clock_rises_r;
    logic [15:0] mosi_cap_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q_r <= 1'h0;
            ssi_clock_q_r <= 1'h1;
            sclk_rises_r <= '0;
            ssi_clock_rises_r <= '0;
            mosi_cap_r <= '0;
        end else begin
            sclk_q_r <= spi_sclk_o;
            ssi_clock_q_r <= ssi_clock_o;
            if (spi_cs_n_o) begin
                sclk_rises_r <= '0;
                mosi_cap_r <= '0;
            end else if (spi_sclk_o && !sclk_q_r) begin
                sclk_rises_r <= sclk_rises_r + 1'h1;
                mosi_cap_r <= {mosi_cap_r[14:0], spi_mosi_o};
            end
            if (eng_start) begin
                ssi_clock_rises_r <= '0;
            end else if (ssi_clock_o && !ssi_clock_q_r) begin
                ssi_clock_rises_r <= ssi_clock_rises_r + 1'h1;
            end
        end
    end

    AST_CS_IDLE_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_r == ST_IDLE) |-> spi_cs_n_o)
        else $error("select low while idle");
    AST_SCLK_HIGH_MIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(spi_sclk_o) |=> spi_sclk_o)
        else $error("serial clock high phase too short");
    AST_SCLK_LOW_MIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(spi_sclk_o) |=> !spi_sclk_o)
        else $error("serial clock low phase too short");
    AST_MOSI_STABLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(spi_sclk_o) |-> $stable(spi_mosi_o))
        else $error("MOSI changed on sampling edge");
    AST_FRAME_PULSES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(spi_cs_n_o) |-> (sclk_rises_r == $past(frame_pulses)))
        else $error("wrong clock count in SPI frame");
    AST_READ_CMD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ($rose(spi_cs_n_o) && $past(first_of_two) && (op_r == OP_REG_READ))
        |-> (mosi_cap_r[15:13] == CMD_REG_READ) && (mosi_cap_r[12:8] == addr_r)
            && (mosi_cap_r[7:0] == READ_FILL))
        else $error("bad read request frame");
    AST_WRITE_CMD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ($rose(spi_cs_n_o) && $past(first_of_two) && (op_r == OP_REG_WRITE))
        |-> (mosi_cap_r == {CMD_REG_WRITE, addr_r, wdata_r}))
        else $error("bad write request frame");
    AST_ZERO_MOSI: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ($rose(spi_cs_n_o) && !$past(first_of_two)) |-> (mosi_cap_r == 16'h0000))
        else $error("MOSI not zero in response or angle frame");
    AST_NVM_WAIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ($fell(spi_cs_n_o) && frame2_r && (op_r == OP_REG_WRITE))
        |-> ($past(idle_cnt_r) >= GAP_W'(NVM_WAIT_CYCLES)))
        else $error("write response frame started too early");
    AST_SELECT_GAP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(spi_cs_n_o) |-> ($past(idle_cnt_r) >= GAP_W'(ANGLE_GAP_CYC))
            && (!(reg_op || (last_op_r != OP_SPI_ANGLE))
                || ($past(idle_cnt_r) >= GAP_W'(REG_GAP_CYC))))
        else $error("select idle time too short");
    AST_SSI_DEAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (eng_start && link_ssi && (last_op_r == OP_SSI_ANGLE))
        |-> (idle_cnt_r >= GAP_W'(SSI_DEAD_CYC)))
        else $error("SSI dead time too short");
    AST_SSI_PULSES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ssi_done |=> (ssi_clock_rises_r == frame_pulses) && rsp_valid_o)
        else $error("wrong SSI clock count or missing response");

endmodule

// File: dv/angle_sensor_model.sv
// Behavioural angle sensor answering on its SPI and SSI pins
`timescale 1ns/1ps
module angle_sensor_model #(
    parameter int NVM_NS = 4000,
    parameter int MONO_NS = 25000
) (
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    input wire logic ssi_clock_i,
    output logic ssi_data_o
);
    logic [7:0] regs_r [0:31];
    logic [7:0] old_r = 8'h00;
    logic [11:0] src_r = 12'h5A3;
    logic frozen_r = 1'b0;
    logic mode3_r = 1'b0;
    logic [15:0] word_r = 16'h0000;
    logic [16:0] sh_r = 17'h00000;
    logic [15:0] rx_r = 16'h0000;
    logic [15:0] rx16_r = 16'h0000;
    logic [15:0] cmd_r = 16'h0000;
    logic [15:0] last_cmd_r = 16'h0000;
    int nbits = 0;
    int nssi = 0;
    realtime wr_t = 0.0;
    realtime ssi_t = -1.0e9;

    // ==========================================================
    // Angle source, 12 useful bits
    initial begin
        ssi_data_o = 1'b0;
        foreach (regs_r[i]) regs_r[i] = 8'h00;
        forever begin
            #1000;
            if (!frozen_r) src_r = src_r + 12'h5A3;
        end
    end

    // ==========================================================
    // SPI slave, modes 0 and 3; MISO has a pull-down when released
    assign spi_miso_o = spi_cs_n_i ? 1'b0 : sh_r[16];
    always @(negedge spi_cs_n_i) begin
        frozen_r = 1'b1;
        nbits = 0;
        mode3_r = spi_sclk_i;
        if (cmd_r[15:13] == 3'h2)
            word_r = {regs_r[cmd_r[12:8]], 8'h00};
        else if (cmd_r[15:13] == 3'h4)
            word_r = {(($realtime - wr_t) < NVM_NS) ? old_r : regs_r[cmd_r[12:8]], 8'h00};
        else
            word_r = {src_r, 4'h0};
        sh_r = {word_r, ^word_r};
    end
    // A mode 3 master opens with a falling edge that still carries the MSB
    always @(negedge spi_sclk_i) if (!spi_cs_n_i) begin
        if (mode3_r) mode3_r = 1'b0;
        else sh_r = sh_r << 1;
    end
    always @(posedge spi_sclk_i) if (!spi_cs_n_i) begin
        rx_r = {rx_r[14:0], spi_mosi_i};
        nbits++;
        if (nbits == 16) rx16_r = rx_r;
    end
    always @(posedge spi_cs_n_i) begin
        frozen_r = 1'b0;
        cmd_r = (nbits >= 16) ? rx16_r : 16'h0000;
        if (cmd_r != 16'h0000) last_cmd_r = cmd_r;
        if (cmd_r[15:13] == 3'h4) begin
            old_r = regs_r[cmd_r[12:8]];
            regs_r[cmd_r[12:8]] = cmd_r[7:0];
            wr_t = $realtime;
        end
    end

    // ==========================================================
    // SSI slave, angle only, dummy clock first
    always @(negedge ssi_clock_i) begin
        if (($realtime - ssi_t) > MONO_NS) nssi = 0;
        nssi++;
        ssi_t = $realtime;
        if (nssi == 1) begin
            word_r = {src_r, 4'h0};
            sh_r = {word_r, ^word_r};
            ssi_data_o = ~sh_r[16];
        end else begin
            ssi_data_o = sh_r[16];
            sh_r = sh_r << 1;
        end
    end
endmodule

// File: dv/angle_sensor_host_test.sv
// Self-checking bench for the angle sensor host controller
`timescale 1ns/1ps
module angle_sensor_host_test;
    import angle_host_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    op_t cmd_op_i = OP_SPI_ANGLE;
    logic [4:0] cmd_addr_i = 5'h00;
    logic [7:0] cmd_wdata_i = 8'h00;
    logic [4:0] cmd_bits_i = 5'h10;
    logic cmd_parity_i = 1'b0;
    logic cmd_ready_o, rsp_valid_o, rsp_parity_bit_o, rsp_parity_err_o, rsp_match_o;
    logic [15:0] rsp_data_o;
    logic spi_cs_n_o, spi_sclk_o, spi_mosi_o, spi_miso_i, ssi_clock_o, ssi_data_i;
    int fail_count = 0;
    int n_tests = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    angle_sensor_host #(.HALF_CYC(4), .NVM_WAIT_CYCLES(200)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
        .cmd_wdata_i(cmd_wdata_i), .cmd_bits_i(cmd_bits_i), .cmd_parity_i(cmd_parity_i),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .rsp_parity_bit_o(rsp_parity_bit_o), .rsp_parity_err_o(rsp_parity_err_o),
        .rsp_match_o(rsp_match_o), .spi_cs_n_o(spi_cs_n_o), .spi_sclk_o(spi_sclk_o),
        .spi_mosi_o(spi_mosi_o), .spi_miso_i(spi_miso_i), .ssi_clock_o(ssi_clock_o),
        .ssi_data_i(ssi_data_i));
    angle_sensor_model #(.NVM_NS(4000), .MONO_NS(25000)) model (
        .spi_cs_n_i(spi_cs_n_o), .spi_sclk_i(spi_sclk_o), .spi_mosi_i(spi_mosi_o),
        .spi_miso_o(spi_miso_i), .ssi_clock_i(ssi_clock_o), .ssi_data_o(ssi_data_i));

    // ==========================================================
    // Report and compare helpers
    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask

    // ==========================================================
    // One command, held until taken, then wait for the response
    task automatic run_op(input op_t op, input logic [4:0] a, input logic [7:0] d,
            input logic [4:0] b, input logic p);
        int i;
        i = 0;
        @(posedge sys_clk_i);
        cmd_op_i <= op;
        cmd_addr_i <= a;
        cmd_wdata_i <= d;
        cmd_bits_i <= b;
        cmd_parity_i <= p;
        cmd_valid_i <= 1'b1;
        while (i < 40000) begin
            @(negedge sys_clk_i);
            i++;
            if (cmd_ready_o === 1'b1) break;
        end
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b0;
        while (i < 40000) begin
            @(negedge sys_clk_i);
            i++;
            if (rsp_valid_o === 1'b1) break;
        end
        if (i >= 40000) begin
            fail_count++;
            $display("Error at %0t: operation timed out", $time);
            wrap_up();
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_angle_full();
        run_op(OP_SPI_ANGLE, 5'h00, 8'h00, 5'h10, 1'b1);
        chk16(rsp_data_o, model.word_r);
        chk1(rsp_parity_bit_o, ^model.word_r);
        chk1(rsp_parity_err_o, 1'b0);
        chk16(model.rx16_r, 16'h0000);
    endtask
    task automatic t_angle_short();
        run_op(OP_SPI_ANGLE, 5'h00, 8'h00, 5'h05, 1'b0);
        chk16(rsp_data_o, model.word_r & 16'hF800);
        chk1(rsp_parity_bit_o, 1'b0);
    endtask
    task automatic t_write();
        run_op(OP_REG_WRITE, 5'h09, 8'hA5, 5'h10, 1'b1);
        chk16(model.last_cmd_r, 16'h89A5);
        chk16(rsp_data_o & 16'hFF00, 16'hA500);
        chk1(rsp_match_o, 1'b1);
        chk1(rsp_parity_err_o, 1'b0);
    endtask
    task automatic t_read();
        run_op(OP_REG_READ, 5'h09, 8'h00, 5'h10, 1'b1);
        chk16(model.last_cmd_r, 16'h4900);
        chk16(rsp_data_o, 16'hA500);
        chk1(rsp_parity_bit_o, 1'b0);
        chk1(rsp_match_o, 1'b0);
    endtask
    task automatic t_ssi();
        run_op(OP_SSI_ANGLE, 5'h00, 8'h00, 5'h10, 1'b1);
        chk16(rsp_data_o, model.word_r);
        chk1(rsp_parity_bit_o, ^model.word_r);
        chk1(spi_cs_n_o, 1'b1);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        chk1(spi_cs_n_o, 1'b1);
        chk1(ssi_clock_o, 1'b1);
        rst_i <= 1'b0;
        t_angle_full();
        t_angle_short();
        t_write();
        t_read();
        t_ssi();
        t_ssi();
        t_angle_full();
        wrap_up();
    end
endmodule
